// ===== common/phy_cfg_defs.svh
// Constants of the strap, reset and mode-configuration block.
// Assumes a 125 MHz core clock; register offsets are the 5-bit management indices.
`ifndef PHY_CFG_DEFS_SVH
`define PHY_CFG_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 8
`define RESET_MIN_NS 200
`define RESET_MIN_CYC ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CALIB_MS 40
`define CALIB_CYC (`CALIB_MS * 1000000 / `CLK_PERIOD_NS)
`define BIT_TIME_NS 100
`define HB_BITS 10
`define HB_CYC (`HB_BITS * `BIT_TIME_NS / `CLK_PERIOD_NS)
`define SOFT_HOLD_CYC 256
`define STRAP_MIN_EDGES 8

// ****************************************
// Register offsets
// ****************************************
`define REG_CONTROL 5'h00
`define REG_ADVERT 5'h04
`define REG_IRQ_STATUS 5'h11
`define REG_PCS_CFG 5'h17
`define REG_LOOP_CFG 5'h18
`define REG_TENBT_CFG 5'h1c

// ****************************************
// Field positions and values
// ****************************************
`define CTL_RESET_BIT 15
`define CTL_LOOP_BIT 14
`define CTL_SPEED_BIT 13
`define CTL_DUPLEX_BIT 12
`define CTL_ISOLATE_BIT 10
`define CTL_ANEN_BIT 8
`define ADV_PAUSE_BIT 10
`define ADV_ABIL_LSB 5
`define ADV_SELECTOR 5'h01
`define PCS_DIGRST_BIT 0
`define LOOP_PMD_BIT 8
`define LOOP_EN_BIT 11
`define TENBT_HB_BIT 1
`define IRQ_CALDONE_BIT 0
`define IRQ_SPEED_BIT 1
`define ADV_10H 5'h01
`define ADV_10F 5'h02
`define ADV_100H 5'h04
`define ADV_100F 5'h08
`define ADV_ALL 5'h0f

`endif

// ===== common/phy_cfg_pkg.sv
// Types shared by the mode-configuration block and its strap classifier.
// Assumes nothing beyond a SystemVerilog elaborator.
package phy_cfg_pkg;
  typedef enum logic [1:0] {
    STRAP_LOW = 2'b00,
    STRAP_HIGH = 2'b01,
    STRAP_MID = 2'b10,
    STRAP_CLK = 2'b11
  } strap_t;

  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_CALIB = 2'b01,
    ST_READY = 2'b10
  } rst_state_t;

  typedef struct packed {
    logic anEn;
    logic speed;
    logic duplex;
    logic [4:0] adv;
  } mode_t;
endpackage : phy_cfg_pkg

// ===== rtl/phy_mode_config_and_reset.sv
// Strap decoding, reset sequencing, mode registers and MII side-band for a 10/100 PHY.
// Assumes a 125 MHz core clock; MAC-side and pad inputs are asynchronous, the
// line receive path (lineRx*) runs on core_clk.
// Notes on behaviour
// - Heartbeat: collision pulse of ten bit times after transmit
// - Heartbeat defaults off unless repeater strap high
// - Loopback returns transmit nibbles to receive outputs
// - Serial strap: one-bit data at 10 MHz
// - Serial mode frames receive data with carrier sense
// - Negotiation straps sampled and classified during reset
// - Clocked only with eight edges during reset
// - Forced speed and duplex decoded from straps
// - Negotiated abilities decoded from straps
// - Clock-strap forced modes rewrite advertisement register
// - Software sets negotiation enable and advertised abilities
// - Parallel detection from line activity without negotiation
// - Reset pin high 200 ns resets all but the interrupt status and a running heartbeat
// - Control bit 15 write gives the same reset as the pin
// - Digital reset bit leaves analog untouched
// - Analog recalibration on power-down or speed change
// - Straps latched after reset, then calibration runs
// - Reset bit reads one until calibration ends
// - Interrupt output follows recorded status changes
// - Receive outputs float when receive enable low
// - Isolate strap sets isolate reset value
`timescale 1ns/1ps
`include "phy_cfg_defs.svh"

module phy_mode_config_and_reset #(
  parameter int CALIB_CYC = `CALIB_CYC,
  parameter int HOLD_CYC = `SOFT_HOLD_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Pins and straps
  input wire logic resetPin,
  input wire logic loopbackPin,
  input wire logic powerDownPin,
  input wire logic rxEnPin,
  input wire logic serialModeStrap,
  input wire logic repeaterStrap,
  input wire logic isolateDefaultStrap,
  input wire logic negotiationStrapHiAbove,
  input wire logic negotiationStrapHiBelow,
  input wire logic negotiationStrapLoAbove,
  input wire logic negotiationStrapLoBelow,
  // Line activity from the analog front end
  input wire logic fastActivity,
  input wire logic slowLinkActivity,
  input wire logic negotiationPulseBurst,
  // MII transmit from the MAC
  input wire logic txEn,
  input wire logic [3:0] txd,
  // Receive path from the line decoder
  input wire logic [3:0] lineRxd,
  input wire logic lineRxDv,
  input wire logic lineCrs,
  input wire logic lineCol,
  // MII receive and status pins
  output logic [3:0] rxd,
  output logic rxDv,
  output logic crs,
  output logic col,
  output logic rxOe,
  // Status and control outputs
  output logic irqOut,
  output logic fastSpeedIndicator,
  output logic slowSpeedIndicator,
  output logic fullDuplex,
  output logic serialMode,
  output logic loopbackActive,
  output logic analogRecal,
  output logic resetBusy
);

  generate
    if (CALIB_CYC < 2 || CALIB_CYC >= 2 ** 23) begin : gBadCalib
      $error("CALIB_CYC out of range");
    end
    if (HOLD_CYC < 1 || HOLD_CYC > 511) begin : gBadHold
      $error("HOLD_CYC out of range");
    end
  endgenerate

  localparam phy_cfg_pkg::strap_t SL = phy_cfg_pkg::STRAP_LOW;
  localparam phy_cfg_pkg::strap_t SH = phy_cfg_pkg::STRAP_HIGH;
  localparam phy_cfg_pkg::strap_t SM = phy_cfg_pkg::STRAP_MID;
  localparam phy_cfg_pkg::strap_t SC = phy_cfg_pkg::STRAP_CLK;
  localparam logic [4:0] RESET_CYC = 5'(`RESET_MIN_CYC);
  localparam logic [6:0] HB_CYC = 7'(`HB_CYC);

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [14:0] syncA;
  logic [14:0] syncB;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= 15'h0000;
      syncB <= 15'h0000;
    end else begin
      syncA <= {resetPin, loopbackPin, powerDownPin, rxEnPin, serialModeStrap, repeaterStrap,
                isolateDefaultStrap, fastActivity, slowLinkActivity, negotiationPulseBurst, txEn, txd};
      syncB <= syncA;
    end
  end

  wire resetPinS = syncB[14];
  wire loopPinS = syncB[13];
  wire powerDownS = syncB[12];
  wire rxEnS = syncB[11];
  wire serialS = syncB[10];
  wire repeaterS = syncB[9];
  wire isoS = syncB[8];
  wire fastS = syncB[7];
  wire slowS = syncB[6];
  wire burstS = syncB[5];
  wire txEnS = syncB[4];
  wire [3:0] txdS = syncB[3:0];

  // ****************************************
  // Reset sources and sequence
  // ****************************************
  logic [4:0] pinCnt;
  phy_cfg_pkg::rst_state_t state;
  logic [8:0] holdCnt;
  logic [22:0] calibCnt;
  logic cfgLoad;
  logic digReq;

  // Pin counts as reset only once high for the least pulse width
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinCnt <= 5'h00;
    end else if (!resetPinS) begin
      pinCnt <= 5'h00;
    end else if (pinCnt != RESET_CYC) begin
      pinCnt <= pinCnt + 5'h01;
    end
  end

  wire pinReset = pinCnt == RESET_CYC;
  wire softReq = regWr && regAddr == `REG_CONTROL && regWdata[`CTL_RESET_BIT];
  wire latchNow = state == phy_cfg_pkg::ST_HOLD && holdCnt == 9'h000 && !pinReset && !softReq;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= phy_cfg_pkg::ST_HOLD;
      holdCnt <= 9'(HOLD_CYC);
      calibCnt <= 23'h000000;
    end else if (pinReset || softReq) begin
      state <= phy_cfg_pkg::ST_HOLD;
      holdCnt <= 9'(HOLD_CYC);
    end else begin
      unique case (state)
        phy_cfg_pkg::ST_HOLD: begin
          if (holdCnt == 9'h000) begin
            state <= phy_cfg_pkg::ST_CALIB;
            calibCnt <= 23'(CALIB_CYC);
          end else begin
            holdCnt <= holdCnt - 9'h001;
          end
        end
        phy_cfg_pkg::ST_CALIB: begin
          if (calibCnt <= 23'h000001) begin
            state <= phy_cfg_pkg::ST_READY;
          end else begin
            calibCnt <= calibCnt - 23'h000001;
          end
        end
        phy_cfg_pkg::ST_READY: begin
          state <= phy_cfg_pkg::ST_READY;
        end
        default: begin
          state <= phy_cfg_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // Digital reset reloads the registers but issues no analog recalibration
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfgLoad <= 1'b0;
      digReq <= 1'b0;
    end else begin
      cfgLoad <= latchNow;
      digReq <= regWr && regAddr == `REG_PCS_CFG && regWdata[`PCS_DIGRST_BIT];
    end
  end

  wire reloadNow = cfgLoad || digReq;
  wire inHold = state == phy_cfg_pkg::ST_HOLD;
  wire calDone = state == phy_cfg_pkg::ST_CALIB && calibCnt <= 23'h000001 && !pinReset && !softReq;

  // ****************************************
  // Strap capture
  // ****************************************
  phy_cfg_pkg::strap_t clsHi;
  phy_cfg_pkg::strap_t clsLo;
  logic repLatched;
  logic isoLatched;

  strap_classifier #(.MIN_EDGES(`STRAP_MIN_EDGES)) uStrapHi (
    .core_clk(core_clk),
    .nrst(nrst),
    .sampleWindow(inHold),
    .latchNow(latchNow),
    .aboveHigh(negotiationStrapHiAbove),
    .belowLow(negotiationStrapHiBelow),
    .strapClass(clsHi)
  );

  strap_classifier #(.MIN_EDGES(`STRAP_MIN_EDGES)) uStrapLo (
    .core_clk(core_clk),
    .nrst(nrst),
    .sampleWindow(inHold),
    .latchNow(latchNow),
    .aboveHigh(negotiationStrapLoAbove),
    .belowLow(negotiationStrapLoBelow),
    .strapClass(clsLo)
  );

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      serialMode <= 1'b0;
      repLatched <= 1'b0;
      isoLatched <= 1'b0;
    end else if (latchNow) begin
      serialMode <= serialS;
      repLatched <= repeaterS;
      isoLatched <= isoS;
    end
  end

  function automatic phy_cfg_pkg::mode_t decodeMode(phy_cfg_pkg::strap_t hi, phy_cfg_pkg::strap_t lo);
    phy_cfg_pkg::mode_t m;
    m = '{1'b1, 1'b1, 1'b1, `ADV_ALL};
    unique case ({hi, lo})
      {SL, SM}: m = '{1'b0, 1'b0, 1'b0, `ADV_ALL};
      {SH, SM}: m = '{1'b0, 1'b0, 1'b1, `ADV_ALL};
      {SM, SL}: m = '{1'b0, 1'b1, 1'b0, `ADV_ALL};
      {SM, SH}: m = '{1'b0, 1'b1, 1'b1, `ADV_ALL};
      {SC, SM}: m = '{1'b0, 1'b1, 1'b1, `ADV_100F | `ADV_100H};
      {SM, SC}: m = '{1'b0, 1'b1, 1'b1, `ADV_100F | `ADV_10F};
      {SC, SC}: m = '{1'b0, 1'b1, 1'b0, `ADV_100H | `ADV_10H};
      {SM, SM}: m = '{1'b1, 1'b1, 1'b1, `ADV_ALL};
      {SL, SL}: m = '{1'b1, 1'b0, 1'b0, `ADV_10H};
      {SL, SH}: m = '{1'b1, 1'b0, 1'b1, `ADV_10F};
      {SH, SL}: m = '{1'b1, 1'b1, 1'b0, `ADV_100H};
      {SH, SH}: m = '{1'b1, 1'b1, 1'b1, `ADV_100F};
      {SC, SH}: m = '{1'b1, 1'b1, 1'b1, `ADV_100F | `ADV_10F};
      {SC, SL}: m = '{1'b1, 1'b1, 1'b0, `ADV_100H | `ADV_10H};
      {SH, SC}: m = '{1'b1, 1'b1, 1'b1, `ADV_100F | `ADV_100H};
      {SL, SC}: m = '{1'b1, 1'b0, 1'b1, `ADV_10F | `ADV_10H};
    endcase
    return m;
  endfunction : decodeMode

  wire phy_cfg_pkg::mode_t strapMode = decodeMode(clsHi, clsLo);

  // ****************************************
  // Mode registers
  // ****************************************
  logic loopBit;
  logic speedBit;
  logic duplexBit;
  logic isoBit;
  logic anEnBit;
  logic [4:0] adv;
  logic loopPmd;
  logic loopEn;
  logic hbEn;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {loopBit, speedBit, duplexBit, isoBit, anEnBit, loopPmd, loopEn, hbEn} <= 8'h00;
      adv <= 5'h00;
    end else if (inHold) begin
      {loopBit, speedBit, duplexBit, isoBit, anEnBit, loopPmd, loopEn, hbEn} <= 8'h00;
      adv <= 5'h00;
    end else if (reloadNow) begin
      loopBit <= 1'b0;
      speedBit <= strapMode.speed;
      duplexBit <= strapMode.duplex;
      anEnBit <= strapMode.anEn;
      adv <= strapMode.adv;
      isoBit <= isoLatched;
      loopPmd <= 1'b0;
      loopEn <= 1'b0;
      hbEn <= repLatched;
    end else if (regWr) begin
      unique case (regAddr)
        `REG_CONTROL: begin
          loopBit <= regWdata[`CTL_LOOP_BIT];
          speedBit <= regWdata[`CTL_SPEED_BIT];
          duplexBit <= regWdata[`CTL_DUPLEX_BIT];
          isoBit <= regWdata[`CTL_ISOLATE_BIT];
          anEnBit <= regWdata[`CTL_ANEN_BIT];
        end
        `REG_ADVERT: begin
          adv <= {regWdata[`ADV_PAUSE_BIT], regWdata[`ADV_ABIL_LSB+3:`ADV_ABIL_LSB]};
        end
        `REG_LOOP_CFG: begin
          loopPmd <= regWdata[`LOOP_PMD_BIT];
          loopEn <= regWdata[`LOOP_EN_BIT];
        end
        `REG_TENBT_CFG: begin
          hbEn <= regWdata[`TENBT_HB_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Speed resolution and analog recalibration
  // ****************************************
  logic next_speed;
  logic next_duplex;
  logic pdPrev;

  always_comb begin
    next_speed = fastSpeedIndicator;
    next_duplex = fullDuplex;
    if (!anEnBit || burstS) begin
      next_speed = speedBit;
      next_duplex = duplexBit;
    end else if (fastS) begin
      next_speed = 1'b1;
      next_duplex = 1'b0;
    end else if (slowS) begin
      next_speed = 1'b0;
      next_duplex = 1'b0;
    end
  end

  wire speedChange = !inHold && next_speed != fastSpeedIndicator;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      fastSpeedIndicator <= 1'b0;
      slowSpeedIndicator <= 1'b1;
      fullDuplex <= 1'b0;
      pdPrev <= 1'b0;
      analogRecal <= 1'b0;
      resetBusy <= 1'b1;
    end else begin
      fastSpeedIndicator <= next_speed;
      slowSpeedIndicator <= !next_speed;
      fullDuplex <= next_duplex;
      pdPrev <= powerDownS;
      analogRecal <= latchNow || powerDownS != pdPrev || speedChange;
      resetBusy <= state != phy_cfg_pkg::ST_READY;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  logic [1:0] irqStat;
  logic [1:0] next_irqStat;

  // A change landing on the read that clears the status is kept
  always_comb begin
    next_irqStat = irqStat;
    if (regRd && regAddr == `REG_IRQ_STATUS) begin
      next_irqStat = 2'h0;
    end
    if (calDone) begin
      next_irqStat[`IRQ_CALDONE_BIT] = 1'b1;
    end
    if (speedChange) begin
      next_irqStat[`IRQ_SPEED_BIT] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqStat <= 2'h0;
      irqOut <= 1'b0;
    end else begin
      irqStat <= next_irqStat;
      irqOut <= |next_irqStat;
    end
  end

  // ****************************************
  // Receive side, loopback and heartbeat
  // ****************************************
  logic txEnPrev;
  logic [6:0] hbCnt;
  wire next_loop = loopBit || (loopPmd && loopEn) || loopPinS;
  wire [3:0] srcD = next_loop ? txdS : lineRxd;
  wire srcDv = next_loop ? txEnS : lineRxDv;
  wire srcCrs = next_loop ? txEnS : lineCrs;
  wire hbActive = hbCnt != 7'h00;

  // Heartbeat starts two cycles after the end of transmit, well inside 1 us
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txEnPrev <= 1'b0;
      hbCnt <= 7'h00;
    end else begin
      txEnPrev <= txEnS;
      if (hbEn && txEnPrev && !txEnS) begin
        hbCnt <= HB_CYC;
      end else if (hbActive) begin
        hbCnt <= hbCnt - 7'h01;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxd <= 4'h0;
      rxDv <= 1'b0;
      crs <= 1'b0;
      col <= 1'b0;
      rxOe <= 1'b0;
      loopbackActive <= 1'b0;
    end else begin
      rxd <= serialMode ? {3'h0, srcD[0]} : srcD;
      rxDv <= serialMode ? 1'b0 : srcDv;
      crs <= srcCrs;
      col <= (lineCol && !next_loop) || hbActive;
      rxOe <= rxEnS && !isoBit;
      loopbackActive <= next_loop;
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      unique case (regAddr)
        `REG_CONTROL: regRdata <= {state != phy_cfg_pkg::ST_READY, loopBit, speedBit, duplexBit, 1'b0,
                                   isoBit, 1'b0, anEnBit, 8'h00};
        `REG_ADVERT: regRdata <= {5'h00, adv[4], 1'b0, adv[3:0], `ADV_SELECTOR};
        `REG_IRQ_STATUS: regRdata <= {14'h0000, irqStat};
        `REG_LOOP_CFG: regRdata <= {4'h0, loopEn, 2'h0, loopPmd, 8'h00};
        `REG_TENBT_CFG: regRdata <= {14'h0000, hbEn, 1'b0};
        default: regRdata <= 16'h0000;
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence txEndSeq;
    hbEn && txEnPrev && !txEnS;
  endsequence

  hb_start_a: assert property (txEndSeq |-> ##2 col[*8])
    else $error("heartbeat collision pulse missing");
  hb_default_a: assert property (cfgLoad |=> hbEn == $past(repLatched))
    else $error("heartbeat default not taken from repeater strap");
  loop_data_a: assert property (next_loop && !serialMode |=> rxd == $past(txdS))
    else $error("loopback data not returned");
  serial_dv_a: assert property (serialMode |=> !rxDv)
    else $error("valid driven in serial mode");
  pin_reset_a: assert property (resetPinS [*8] ##1 pinReset |=> state == phy_cfg_pkg::ST_HOLD)
    else $error("reset pin did not reset");
  soft_reset_a: assert property (softReq |=> inHold ##1 inHold)
    else $error("control reset ignored");
  strap_latch_a: assert property (latchNow |=> cfgLoad ##1 state == phy_cfg_pkg::ST_CALIB)
    else $error("strap latch out of order");
  adv_rewrite_a: assert property (cfgLoad && clsHi == SC && clsLo == SM |=> adv == 5'h0c)
    else $error("advertisement not rewritten");
  busy_bit_a: assert property (regRd && regAddr == `REG_CONTROL &&
    state != phy_cfg_pkg::ST_READY |=> regRdata[15])
    else $error("reset bit wrong");
  irq_follow_a: assert property (calDone |=> irqOut)
    else $error("interrupt not raised");
  rx_float_a: assert property (!rxEnS || isoBit |=> !rxOe)
    else $error("receive outputs driven while disabled");
  recal_pd_a: assert property (powerDownS != pdPrev |=> analogRecal)
    else $error("no recalibration on power-down change");

endmodule : phy_mode_config_and_reset

// ===== rtl/strap_classifier.sv
// Classifies one three-level strap pin as low, high, mid-level or clocked.
// Assumes two comparator outputs from the pin pad, asynchronous to core_clk.
`timescale 1ns/1ps
`include "phy_cfg_defs.svh"

module strap_classifier #(
  parameter int MIN_EDGES = `STRAP_MIN_EDGES
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Sampling control
  input wire logic sampleWindow,
  input wire logic latchNow,
  // Pad comparators
  input wire logic aboveHigh,
  input wire logic belowLow,
  // Result
  output phy_cfg_pkg::strap_t strapClass
);

  generate
    if (MIN_EDGES < 1 || MIN_EDGES > 15) begin : gBadEdges
      $error("MIN_EDGES must be 1 to 15");
    end
  endgenerate

  logic [1:0] syncA;
  logic [1:0] syncB;
  logic prevHigh;
  logic [3:0] edgeCnt;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      syncA <= 2'h0;
      syncB <= 2'h0;
    end else begin
      syncA <= {aboveHigh, belowLow};
      syncB <= syncA;
    end
  end

  // ****************************************
  // Clock edge count during reset
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prevHigh <= 1'b0;
      edgeCnt <= 4'h0;
    end else begin
      prevHigh <= syncB[1];
      if (latchNow) begin
        edgeCnt <= 4'h0;
      end else if (sampleWindow && syncB[1] && !prevHigh && edgeCnt != 4'hf) begin
        edgeCnt <= edgeCnt + 4'h1;
      end
    end
  end

  // Clock wins over level: a clocked pin shows a random level at the latch
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      strapClass <= phy_cfg_pkg::STRAP_MID;
    end else if (latchNow) begin
      if (edgeCnt >= 4'(MIN_EDGES)) begin
        strapClass <= phy_cfg_pkg::STRAP_CLK;
      end else if (syncB[1]) begin
        strapClass <= phy_cfg_pkg::STRAP_HIGH;
      end else if (syncB[0]) begin
        strapClass <= phy_cfg_pkg::STRAP_LOW;
      end else begin
        strapClass <= phy_cfg_pkg::STRAP_MID;
      end
    end
  end

endmodule : strap_classifier

// ===== testbench/mac_model.sv
// MAC transmit model: sends one frame of a fixed nibble on request.
// Assumes start is a one-cycle pulse on core_clk.
`timescale 1ns/1ps
module mac_model #(
  parameter int LEN = 16
) (
  // Clock
  input wire logic core_clk,
  // Request
  input wire logic start,
  input wire logic [3:0] nibble,
  // MII transmit
  output logic txEn = 1'b0,
  output logic [3:0] txd = 4'h0
);
  int cnt = 0;
  // Idle data toggles so a stale nibble never passes for a live one
  always @(posedge core_clk) begin
    cnt <= start ? LEN : (cnt != 0 ? cnt - 1 : 0);
    txEn <= start || cnt > 1;
    txd <= (start || cnt > 1) ? nibble : ~txd;
  end
endmodule : mac_model

// ===== testbench/phy_mode_config_and_reset_tb_top.sv
// Bench for strap decoding, reset sequencing and MII side-band.
// Assumes mac_model drives transmit; pads and line inputs are driven here.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module phy_mode_config_and_reset_tb_top;
  // ****
  // Signals
  // ****
  logic core_clk = 0, nrst = 0, regWr = 0, regRd = 0, resetPin = 0, loopbackPin = 0, rxEnPin = 1;
  logic serialModeStrap = 0, repeaterStrap = 0, isolateDefaultStrap = 0, stClk = 0, go = 0, lDv = 0, pd = 0;
  logic txEn, rxDv, crs, col, rxOe, irqOut, fastSpeedIndicator, slowSpeedIndicator, fullDuplex;
  logic serialMode, loopbackActive, analogRecal, resetBusy, lCrs = 0, lCol = 0;
  logic [3:0] txd, rxd, nib = 0, tn = 0;
  logic [1:0] hS = 2, lS = 2;
  logic [4:0] regAddr = 0;
  logic [15:0] regWdata = 0, regRdata, rd, w;
  logic [11:0] t;
  // Entry: hi, lo, -, negotiate, speed100, full, advertised 100F..10H
  logic [11:0] tbl [16] = '{12'h20f, 12'h61f, 12'h82f, 12'h93f, 12'he3c, 12'hb3a, 12'hf25, 12'ha4f,
    12'h041, 12'h142, 12'h444, 12'h548, 12'hd4a, 12'hc45, 12'h74c, 12'h343};
  int num_errors = 0, samples_checked = 0, off;
  wire logic hA = hS == 2'd3 ? stClk : hS == 2'd1;
  wire logic lA = lS == 2'd3 ? stClk : lS == 2'd1;
  always #4 core_clk = ~core_clk;
  always #20 stClk = ~stClk;
  phy_mode_config_and_reset #(.CALIB_CYC(50), .HOLD_CYC(64)) phy_mode_config_and_reset_i (.core_clk, .nrst,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata, .resetPin, .loopbackPin, .powerDownPin(pd), .rxEnPin,
    .serialModeStrap, .repeaterStrap, .isolateDefaultStrap, .negotiationStrapHiAbove(hA),
    .negotiationStrapHiBelow(hS == 2'd0), .negotiationStrapLoAbove(lA), .negotiationStrapLoBelow(lS == 2'd0),
    .fastActivity(1'b0), .slowLinkActivity(1'b0), .negotiationPulseBurst(1'b0), .txEn, .txd, .lineRxd(nib),
    .lineRxDv(lDv), .lineCrs(lCrs), .lineCol(lCol), .rxd, .rxDv, .crs, .col, .rxOe, .irqOut,
    .fastSpeedIndicator, .slowSpeedIndicator, .fullDuplex, .serialMode, .loopbackActive, .analogRecal, .resetBusy);
  mac_model #(.LEN(16)) mac_model_i (.core_clk, .start(go), .nibble(tn), .txEn, .txd);
  // ****
  // Tasks
  // ****
  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask : tick
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1;
    @(posedge core_clk);
    regWr <= 0;
  endtask : wr
  task automatic rdr(input logic [4:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1;
    @(posedge core_clk);
    regRd <= 0;
    #1 rd = regRdata;
  endtask : rdr
  task automatic waitb();
    int n;
    n = 0;
    while (resetBusy !== 1'b0 && n < 400) begin
      tick(1);
      n++;
    end
    if (n >= 400) begin
      num_errors++;
      stop_test();
    end
  endtask : waitb
  task automatic boot(input logic [1:0] h, input logic [1:0] l, input logic [2:0] s);
    @(posedge core_clk);
    nrst <= 0;
    hS <= h;
    lS <= l;
    {serialModeStrap, isolateDefaultStrap, repeaterStrap} <= s;
    tick(10);
    `CHK("rstv", 2'b11, {slowSpeedIndicator, resetBusy})
    @(posedge core_clk);
    nrst <= 1;
    waitb();
  endtask : boot
  task automatic send();
    @(posedge core_clk);
    go <= 1;
    @(posedge core_clk);
    go <= 0;
  endtask : send
  task automatic hb(input int e);
    int c;
    int f;
    c = 0;
    f = -1;
    send();
    repeat (16) @(posedge core_clk);
    for (int i = 0; i < 300; i++) begin
      tick(1);
      if (col === 1'b1 && f < 0) f = i;
      if (col === 1'b1) c++;
    end
    `CHK("hbLen", e, c)
    `CHK("hbStart", 1'b1, f <= 125)
  endtask : hb
  // ****
  // Sequence
  // ****
  initial begin
    void'($urandom(42280));
    off = $urandom % 16;
    for (int i = 0; i < 16; i++) begin
      t = tbl[(i + off) % 16];
      boot(t[11:10], t[9:8], 3'($urandom));
      rdr(5'h04);
      `CHK("adv", t[3:0], rd[8:5])
      rdr(5'h00);
      `CHK("anEn", t[6], rd[8])
      `CHK("iso", isolateDefaultStrap, rd[10])
      `CHK("oe", !rd[10], rxOe)
      `CHK("ser", serialModeStrap, serialMode)
      if (!t[6]) `CHK("mode", t[5:4], {fastSpeedIndicator, fullDuplex})
      rdr(5'h1c);
      `CHK("hbDef", repeaterStrap, rd[1])
    end
    boot(2'd2, 2'd1, 3'b000);
    tick(2);
    `CHK("irq", 1'b1, irqOut)
    rdr(5'h11);
    tick(2);
    `CHK("irqClr", 1'b0, irqOut)
    w = 16'($urandom);
    wr(5'h04, w);
    rdr(5'h04);
    `CHK("advW", {w[10], w[8:5], 5'h01}, {rd[10], rd[8:5], rd[4:0]})
    wr(5'h17, 16'h0001);
    rdr(5'h04);
    `CHK("digRst", 6'h0f, {resetBusy, rd[10], rd[8:5]})
    wr(5'h00, 16'h8000);
    rdr(5'h00);
    `CHK("busy", 1'b1, rd[15])
    waitb();
    rdr(5'h00);
    `CHK("done", 1'b0, rd[15])
    rdr(5'h04);
    `CHK("advRst", 4'hf, rd[8:5])
    hb(0);
    wr(5'h1c, 16'h0002);
    hb(125);
    for (int k = 0; k < 3; k++) begin
      @(posedge core_clk);
      loopbackPin <= k == 0;
      tn <= 4'($urandom);
      wr(5'h00, k == 1 ? 16'h4000 : 16'h0000);
      wr(5'h18, k == 2 ? 16'h0900 : 16'h0000);
      send();
      tick(8);
      `CHK("lb", {2'b11, tn}, {loopbackActive, crs, rxd})
    end
    @(posedge core_clk);
    loopbackPin <= 0;
    wr(5'h00, 16'h0000);
    wr(5'h18, 16'h0000);
    nib <= 4'($urandom);
    lDv <= 1;
    tick(4);
    `CHK("rx", {nib, 1'b1}, {rxd, rxDv})
    rxEnPin <= 0;
    pd <= 1;
    tick(3);
    `CHK("rxOe", 1'b0, rxOe)
    `CHK("recal", 1'b1, analogRecal)
    resetPin <= 1;
    tick(10);
    resetPin <= 0;
    tick(6);
    `CHK("short", 1'b0, resetBusy)
    resetPin <= 1;
    tick(30);
    resetPin <= 0;
    tick(2);
    `CHK("long", 1'b1, resetBusy)
    waitb();
    {lCrs, lCol} <= 2'b11;
    tick(2);
    `CHK("crsCol", 2'b11, {crs, col})
    stop_test();
  end
endmodule : phy_mode_config_and_reset_tb_top
